// File: pkg/pms_defs.svh
`ifndef PMS_DEFS_SVH
`define PMS_DEFS_SVH

`define PMS_ADR_CMD_SNAP     8'h00
`define PMS_ADR_CTRL         8'h01
`define PMS_ADR_CNT_LO       8'h02
`define PMS_ADR_CNT_HI       8'h03
`define PMS_ADR_BUS0         8'h04
`define PMS_ADR_SENSE0       8'h08
`define PMS_ADR_POWER0       8'h0c
`define PMS_ADR_STATE        8'h10
`define PMS_ADR_STATUS       8'h1c
`define PMS_ADR_POLAR        8'h1d
`define PMS_ADR_HALF         8'h1e
`define PMS_ADR_CMD_KEEP     8'h1f
`define PMS_ADR_SLOW         8'h20

`define PMS_CTRL_MODE_LSB    0
`define PMS_CTRL_ALERT_BIT   4
`define PMS_CTRL_CHOFF_LSB   8
`define PMS_SLOW_KEEP_BIT    0
`define PMS_SLOW_ENR_BIT     1
`define PMS_SLOW_ENF_BIT     2
`define PMS_SLOW_LVL_BIT     4
`define PMS_SLOW_RISE_BIT    5
`define PMS_SLOW_FALL_BIT    6
`define PMS_STATUS_POR_BIT   0

`define PMS_CTRL_RST         16'h0000
`define PMS_POLAR_RST        16'h0000
`define PMS_HALF_RST         16'h0000
`define PMS_SLOW_RST         16'h0000

`define PMS_MODE_1024        3'h0
`define PMS_MODE_256         3'h1
`define PMS_MODE_64          3'h2
`define PMS_MODE_8           3'h3
`define PMS_MODE_SINGLE      3'h4
`define PMS_MODE_SLEEP       3'h5

`define PMS_CLK_HZ           250000000
`define PMS_CLK_MHZ          250
`define PMS_SNAP_WIN_US      1000
`define PMS_SS_DLY_US        1000
`define PMS_SPS_1024         1024
`define PMS_SPS_256          256
`define PMS_SPS_64           64
`define PMS_SPS_8            8

`endif

// File: pkg/pms_pkg.sv
package pms_pkg;

    typedef enum logic [2:0] {
        PMS_IDLE  = 3'b001,
        PMS_CONV  = 3'b010,
        PMS_SSDLY = 3'b100
    } pms_state_t;

    typedef struct packed {
        logic [15:0] bus;
        logic [15:0] sense;
        logic [29:0] power;
    } pms_result_t;

    typedef struct packed {
        logic [1:0]  chan;
        logic [16:0] busRaw;
        logic [16:0] senseRaw;
    } pms_sample_t;

    typedef struct packed {
        logic [2:0] mode;
        logic       alertPin;
        logic [3:0] chOff;
        logic [3:0] busBip;
        logic [3:0] senseBip;
        logic [3:0] busHalf;
        logic [3:0] senseHalf;
    } pms_cfg_t;

endpackage

// File: verif/pms_adc_model.sv
module pms_adc_model (
    input  wire logic            clock,
    input  wire logic            reset_n,
    input  wire logic            convStart,
    input  wire logic [16:0]     busBase,
    input  wire logic [16:0]     senseBase,
    input  wire logic [3:0]      gap,
    output logic                 adcValid,
    output pms_pkg::pms_sample_t adcSample
);
    timeunit 1ns;
    timeprecision 1ps;
    import pms_pkg::*;
    int chan;
    int waitN;
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            chan <= 4;
            waitN <= 0;
            adcValid <= 1'b0;
            adcSample <= '0;
        end else begin
            adcValid <= 1'b0;
            // lines do not hold old data once the sample is gone
            if (adcValid)
                adcSample <= ~adcSample;
            if (convStart) begin
                chan <= 0;
                waitN <= gap;
            end else if (chan < 4) begin
                if (waitN > 0)
                    waitN <= waitN - 1;
                else begin
                    adcValid <= 1'b1;
                    adcSample.chan <= chan[1:0];
                    adcSample.busRaw <= busBase + 17'(chan * 'h1000);
                    adcSample.senseRaw <= senseBase - 17'(chan * 'h800);
                    chan <= chan + 1;
                    waitN <= gap;
                end
            end
        end
    end
endmodule // pms_adc_model

// File: verif/pms_top_props.sv
module pms_top_props (
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic [7:0]  regAddr,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [15:0] regRdata,
    input wire logic        cmdNack,
    input wire logic        shutdownPin_n,
    input wire logic        firstAlarmOut,
    input wire logic        firstAlarmOe,
    input wire logic        alarmRequest,
    input wire logic        convStart,
    input wire logic        sleepActive,
    input wire logic        powerDownActive
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    nack_cause_a: assert property (cmdNack |->
        $past(regWrite) && ($past(regAddr) == 8'h00 || $past(regAddr) == 8'h1f))
        else $error("refusal without a command write");
    rdata_idle_a: assert property (!$past(regRead) |-> regRdata == 16'h0000)
        else $error("read data outside its cycle");
    pd_read_a: assert property (powerDownActive && regRead |=> regRdata == 16'h0000)
        else $error("bus answered in power-down");
    pd_enter_a: assert property (!shutdownPin_n [*4] |=> powerDownActive)
        else $error("power-down not entered");
    pd_quiet_a: assert property (powerDownActive |-> !convStart && !cmdNack)
        else $error("activity in power-down");
    conv_pulse_a: assert property (convStart |=> !convStart)
        else $error("cycle start longer than one cycle");
    conv_wake_a: assert property (convStart |-> !sleepActive)
        else $error("cycle started while asleep");
    alarm_follow_a: assert property (firstAlarmOe && $past(firstAlarmOe) |->
        firstAlarmOut == $past(alarmRequest))
        else $error("alarm output not following request");
endmodule // pms_top_props

bind pms_top pms_top_props i_pms_top_props (.clock(clock), .reset_n(reset_n),
    .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .cmdNack(cmdNack), .shutdownPin_n(shutdownPin_n), .firstAlarmOut(firstAlarmOut),
    .firstAlarmOe(firstAlarmOe), .alarmRequest(alarmRequest), .convStart(convStart),
    .sleepActive(sleepActive), .powerDownActive(powerDownActive));

// File: verif/test_pms_top.sv
module test_pms_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pms_pkg::*;
    logic clock, reset_n, regWrite, regRead, cmdNack, shutdownPin_n, slowPinIn;
    logic firstAlarmOut, firstAlarmOe, alarmRequest, convStart, adcValid;
    logic sleepActive, powerDownActive;
    logic [7:0] regAddr;
    logic [15:0] regWdata, regRdata;
    logic [2:0] cycleRate;
    logic [16:0] busBase, senseBase;
    logic [3:0] gap;
    pms_sample_t adcSample;
    int err_count = 0;
    int checks_done = 0;
    int seed;

    pms_top #(.SNAP_CYC(20), .SSDLY_CYC(20), .PER_1024(200), .PER_256(400),
        .PER_64(800), .PER_8(1600)) i_pms_top (.clock(clock), .reset_n(reset_n),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .cmdNack(cmdNack), .shutdownPin_n(shutdownPin_n),
        .slowPinIn(slowPinIn), .firstAlarmOut(firstAlarmOut), .firstAlarmOe(firstAlarmOe),
        .alarmRequest(alarmRequest), .convStart(convStart), .cycleRate(cycleRate),
        .adcValid(adcValid), .adcSample(adcSample), .sleepActive(sleepActive),
        .powerDownActive(powerDownActive));
    pms_adc_model i_pms_adc_model (.clock(clock), .reset_n(reset_n), .convStart(convStart),
        .busBase(busBase), .senseBase(senseBase), .gap(gap), .adcValid(adcValid),
        .adcSample(adcSample));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) alarmRequest <= 1'($urandom);

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1 chk(regRdata, exp);
    endtask
    task automatic waitConv;
        int n;
        for (n = 0; n < 5000; n++) begin
            @(posedge clock);
            if (convStart === 1'b1)
                break;
        end
        if (n == 5000)
            chk(16'h0bad, 16'h0000);
    endtask
    // config only lands through a host snapshot once the busy window is over
    task automatic apply(input logic [15:0] d);
        wr(8'h01, d);
        repeat (30) @(posedge clock);
        wr(8'h1f, 16'h0000);
        waitConv();
        waitConv();
        #1;
    endtask
    task automatic settle;
        repeat (30) @(posedge clock);
        waitConv();
        repeat (40) @(posedge clock);
    endtask
    function automatic logic [15:0] fmt(input logic [16:0] r, input bit bip, input bit half);
        int v;
        v = int'($signed(r));
        if (!bip)
            return (v < 0) ? 16'h0000 : 16'(v);
        if (!half)
            return 16'(v >>> 1);
        if (v > 32767)
            return 16'h7fff;
        if (v < -32768)
            return 16'h8000;
        return 16'(v);
    endfunction
    task automatic results(input bit bip);
        for (int c = 0; c < 2; c++) begin
            rdchk(8'(8'h04 + c), fmt(busBase + 17'(c * 'h1000), bip, c == 0));
            rdchk(8'(8'h08 + c), fmt(senseBase - 17'(c * 'h800), bip, c == 0));
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        #200000;
        err_count++;
        tally_and_finish();
    end

    initial begin
        seed = $urandom(27399);
        {reset_n, regWrite, regRead, slowPinIn} = '0;
        shutdownPin_n = 1'b1;
        regAddr = '0;
        regWdata = '0;
        busBase = 17'($urandom);
        senseBase = 17'($urandom);
        gap = 4'h2;
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        rdchk(8'h1c, 16'h0001);
        rdchk(8'h01, 16'h0000);
        rdchk(8'h20, 16'h0000);
        rdchk(8'h7f, 16'h0000);
        wr(8'h1c, 16'h0001);
        rdchk(8'h1c, 16'h0000);
        settle();
        chk({15'h0, sleepActive}, 16'h0000);
        wr(8'h00, 16'h0000);
        wr(8'h00, 16'h0000);
        #1 chk({15'h0, cmdNack}, 16'h0001);
        results(1'b0);
        wr(8'h1d, 16'h00ff);
        wr(8'h1e, 16'h0011);
        gap <= 4'h0;
        busBase <= 17'($urandom);
        senseBase <= 17'($urandom);
        repeat (30) @(posedge clock);
        wr(8'h1f, 16'h0000);
        settle();
        wr(8'h1f, 16'h0000);
        results(1'b1);
        for (int m = 0; m < 4; m++) begin
            apply(16'h0010 | 16'(m));
            chk({13'h0, cycleRate}, 16'(m));
        end
        repeat (40) @(posedge clock);
        chk({15'h0, sleepActive}, 16'h0001);
        apply(16'h0001);
        slowPinIn <= 1'b1;
        waitConv();
        waitConv();
        #1 chk({13'h0, cycleRate}, 16'h0003);
        apply(16'h0011);
        chk({13'h0, cycleRate}, 16'h0001);
        chk({15'h0, firstAlarmOe}, 16'h0001);
        apply(16'h0001);
        wr(8'h20, 16'h0006);
        repeat (7) #80 slowPinIn <= ~slowPinIn;
        repeat (10) @(posedge clock);
        rdchk(8'h20, 16'h0066);
        wr(8'h01, 16'h0004);
        repeat (30) @(posedge clock);
        wr(8'h1f, 16'h0000);
        repeat (30) @(posedge clock);
        slowPinIn <= 1'b1;
        waitConv();
        #1 chk({13'h0, cycleRate}, 16'h0004);
        wr(8'h01, 16'h0005);
        slowPinIn <= 1'b0;
        repeat (30) @(posedge clock);
        wr(8'h1f, 16'h0000);
        slowPinIn <= 1'b1;
        repeat (60) @(posedge clock);
        #1 chk({13'h0, cycleRate}, 16'h0004);
        chk({15'h0, sleepActive}, 16'h0001);
        shutdownPin_n <= 1'b0;
        repeat (6) @(posedge clock);
        chk({15'h0, powerDownActive}, 16'h0001);
        rdchk(8'h1c, 16'h0000);
        // host side holds off before asking for data after power-up
        shutdownPin_n <= 1'b1;
        repeat (6) @(posedge clock);
        rdchk(8'h01, 16'h0000);
        rdchk(8'h1c, 16'h0001);
        tally_and_finish();
    end
endmodule // test_pms_top

// File: verilog/pms_pin_sync.sv
module pms_pin_sync #(
    parameter logic RST_LVL = 1'b0
) (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic pinAsync,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // meta_reg feeds only sync_reg
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= RST_LVL;
            sync_reg <= RST_LVL;
            last_reg <= RST_LVL;
        end else begin
            meta_reg <= pinAsync;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign rise  = sync_reg & ~last_reg;
    assign fall  = ~sync_reg & last_reg;
endmodule // pms_pin_sync

// File: verilog/pms_top.sv
// Chosen here: the address map and the strobed register port.
`include "pms_defs.svh"

// Summary of operation
// - sleep between cycles when slow or few channels
// - sleep keeps all state and results
// - sleep mode written, applied by snapshot
// - sleep from nothing else; timeout unaffected
// - power-down only by shutdown pin low
// - power-down restores all defaults except pd_reg and the pin synchronizers
// - power-on flag set at reset, host clears
// - slow pin forces 8 SPS next periodic cycle
// - alert assignment frees rate from pin
// - 8 SPS still programmable in alert use
// - single-shot starts 1 ms after pin rise
// - pin starts no cycle in sleep mode
// - pin edges issue limited snapshot
// - pin snapshot leaves pending config alone
// - results stable within 1 ms of edge
// - slow register: type, edge enables, status
// - 16-bit bus word, 14 MSBs form power
// - bipolar bus result is two's complement
// - sense unsigned or two's complement
// - half-range per channel keeps 16 bits
// - commands nacked 1 ms after snapshot
// - keep variant leaves accumulators alone
module pms_top #(
    parameter int unsigned SNAP_CYC  = `PMS_CLK_MHZ * `PMS_SNAP_WIN_US,
    parameter int unsigned SSDLY_CYC = `PMS_CLK_MHZ * `PMS_SS_DLY_US,
    parameter int unsigned PER_1024  = `PMS_CLK_HZ / `PMS_SPS_1024,
    parameter int unsigned PER_256   = `PMS_CLK_HZ / `PMS_SPS_256,
    parameter int unsigned PER_64    = `PMS_CLK_HZ / `PMS_SPS_64,
    parameter int unsigned PER_8     = `PMS_CLK_HZ / `PMS_SPS_8
) (
    input  wire logic                clock,
    input  wire logic                reset_n,
    input  wire logic [7:0]          regAddr,
    input  wire logic [15:0]         regWdata,
    input  wire logic                regWrite,
    input  wire logic                regRead,
    output logic      [15:0]         regRdata,
    output logic                     cmdNack,
    input  wire logic                shutdownPin_n,
    input  wire logic                slowPinIn,
    output logic                     firstAlarmOut,
    output logic                     firstAlarmOe,
    input  wire logic                alarmRequest,
    output logic                     convStart,
    output logic      [2:0]          cycleRate,
    input  wire logic                adcValid,
    input  wire pms_pkg::pms_sample_t adcSample,
    output logic                     sleepActive,
    output logic                     powerDownActive
);
    import pms_pkg::*;

    logic        shutLvl;
    logic        slowLvl;
    logic        slowRise;
    logic        slowFall;
    pms_state_t  state_reg;
    pms_state_t  state_next;
    pms_cfg_t    cfgAct_reg;
    pms_cfg_t    cfgPend_reg;
    logic        applyPend_reg;
    logic [15:0] slowCfg_reg;
    logic        riseSeen_reg;
    logic        fallSeen_reg;
    logic        porFlag_reg;
    logic [31:0] timer_reg;
    logic [31:0] busy_reg;
    logic [31:0] ssCnt_reg;
    logic [31:0] accCount_reg;
    logic [31:0] readCount_reg;
    logic [55:0] acc_reg [4];
    pms_result_t live_reg [4];
    pms_result_t done_reg [4];
    pms_result_t read_reg [4];
    logic [15:0] rdata_reg;
    logic        nack_reg;
    logic        conv_reg;
    logic [2:0]  rate_reg;
    logic        sleep_reg;
    logic        pd_reg;
    logic        alarm_reg;
    logic        alarmOe_reg;

    pms_pin_sync #(.RST_LVL(1'b1)) u_shut (
        .clock   (clock),
        .reset_n (reset_n),
        .pinAsync(shutdownPin_n),
        .level   (shutLvl),
        .rise    (),
        .fall    ()
    );

    pms_pin_sync #(.RST_LVL(1'b0)) u_slow (
        .clock   (clock),
        .reset_n (reset_n),
        .pinAsync(slowPinIn),
        .level   (slowLvl),
        .rise    (slowRise),
        .fall    (slowFall)
    );

    function automatic logic [15:0] fmtWord(input logic [16:0] raw, input logic bip,
                                            input logic half);
        logic [15:0] w;
        if (!bip)
            w = raw[16] ? 16'h0000 : raw[15:0];
        else if (!half)
            w = raw[16:1];
        else if (raw[16] != raw[15])
            w = raw[16] ? 16'h8000 : 16'h7fff;
        else
            w = raw[15:0];
        return w;
    endfunction

    wire pdNow     = ~shutLvl;
    wire wrCmd     = regWrite && !pdNow &&
                     (regAddr == `PMS_ADR_CMD_SNAP || regAddr == `PMS_ADR_CMD_KEEP);
    wire busyWin   = busy_reg != 32'h0;
    wire hostSnap  = wrCmd && !busyWin;
    wire hostKeep  = regAddr == `PMS_ADR_CMD_KEEP;
    wire pinIsIo   = !cfgAct_reg.alertPin;
    wire pinSnap   = pinIsIo && !pdNow &&
                     ((slowRise && slowCfg_reg[`PMS_SLOW_ENR_BIT]) ||
                      (slowFall && slowCfg_reg[`PMS_SLOW_ENF_BIT]));
    wire anySnap   = hostSnap || pinSnap;
    wire clearAcc  = hostSnap ? !hostKeep : (pinSnap && !slowCfg_reg[`PMS_SLOW_KEEP_BIT]);
    wire [2:0] mode      = cfgAct_reg.mode;
    wire       modeSleep = mode == `PMS_MODE_SLEEP;
    wire       modeShot  = mode == `PMS_MODE_SINGLE;
    wire       periodic  = mode <= `PMS_MODE_8;
    wire       allOff    = &cfgAct_reg.chOff;
    // unless pin is an alert output
    wire [2:0] effMode   = (slowLvl && pinIsIo) ? `PMS_MODE_8 : mode;
    wire [31:0] perSel   = (effMode == `PMS_MODE_1024) ? 32'(PER_1024) :
                           (effMode == `PMS_MODE_256)  ? 32'(PER_256)  :
                           (effMode == `PMS_MODE_64)   ? 32'(PER_64)   : 32'(PER_8);
    wire [1:0] lastChan  = !cfgAct_reg.chOff[3] ? 2'h3 :
                           !cfgAct_reg.chOff[2] ? 2'h2 :
                           !cfgAct_reg.chOff[1] ? 2'h1 : 2'h0;
    wire       idle      = state_reg == PMS_IDLE;
    wire       startPer  = idle && periodic && !allOff && timer_reg == 32'h0;
    wire       shotTrig  = idle && modeShot && pinIsIo && slowRise && !allOff;
    wire       ssDone    = state_reg == PMS_SSDLY && ssCnt_reg == 32'h0;
    wire       sampleIn  = adcValid && state_reg == PMS_CONV;
    wire       cycleEnd  = sampleIn && adcSample.chan == lastChan;
    wire [1:0] ch        = adcSample.chan;

    wire [15:0] busWord   = fmtWord(adcSample.busRaw, cfgAct_reg.busBip[ch],
                                    cfgAct_reg.busHalf[ch]);
    wire [15:0] senseWord = fmtWord(adcSample.senseRaw, cfgAct_reg.senseBip[ch],
                                    cfgAct_reg.senseHalf[ch]);
    // upper 14 bus bits times sense
    wire signed [14:0] busOp   = {cfgAct_reg.busBip[ch] & busWord[15], busWord[15:2]};
    wire signed [16:0] senseOp = {cfgAct_reg.senseBip[ch] & senseWord[15], senseWord};
    wire signed [31:0] prod    = 32'(busOp * senseOp);
    wire pms_result_t  newRes  = '{bus: busWord, sense: senseWord, power: prod[29:0]};

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            PMS_IDLE: begin
                if (startPer)
                    state_next = PMS_CONV;
                else if (shotTrig)
                    state_next = PMS_SSDLY;
            end
            PMS_SSDLY: begin
                if (ssDone)
                    state_next = PMS_CONV;
            end
            PMS_CONV: begin
                if (cycleEnd)
                    state_next = PMS_IDLE;
            end
        endcase
    end

    // power-down returns every register to default except pd_reg, which goes high, and the pin synchronizers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n)
            state_reg <= PMS_IDLE;
        else if (pdNow)
            state_reg <= PMS_IDLE;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cfgAct_reg    <= '0;
            cfgPend_reg   <= '0;
            applyPend_reg <= 1'b0;
        end else if (pdNow) begin
            cfgAct_reg    <= '0;
            cfgPend_reg   <= '0;
            applyPend_reg <= 1'b0;
        end else begin
            if (regWrite && regAddr == `PMS_ADR_CTRL) begin
                cfgPend_reg.mode     <= regWdata[`PMS_CTRL_MODE_LSB +: 3];
                cfgPend_reg.alertPin <= regWdata[`PMS_CTRL_ALERT_BIT];
                cfgPend_reg.chOff    <= regWdata[`PMS_CTRL_CHOFF_LSB +: 4];
            end
            if (regWrite && regAddr == `PMS_ADR_POLAR)
                {cfgPend_reg.busBip, cfgPend_reg.senseBip} <= regWdata[7:0];
            if (regWrite && regAddr == `PMS_ADR_HALF)
                {cfgPend_reg.busHalf, cfgPend_reg.senseHalf} <= regWdata[7:0];
            // config changes land only between cycles
            if (applyPend_reg && idle) begin
                cfgAct_reg    <= cfgPend_reg;
                applyPend_reg <= hostSnap;
            end else if (hostSnap) begin
                applyPend_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            slowCfg_reg  <= `PMS_SLOW_RST;
            riseSeen_reg <= 1'b0;
            fallSeen_reg <= 1'b0;
            porFlag_reg  <= 1'b1;
        end else if (pdNow) begin
            slowCfg_reg  <= `PMS_SLOW_RST;
            riseSeen_reg <= 1'b0;
            fallSeen_reg <= 1'b0;
            porFlag_reg  <= 1'b1;
        end else begin
            if (regWrite && regAddr == `PMS_ADR_SLOW)
                slowCfg_reg <= {13'h0000, regWdata[2:0]};
            // set wins over write-one clear
            riseSeen_reg <= slowRise || (riseSeen_reg &&
                !(regWrite && regAddr == `PMS_ADR_SLOW && regWdata[`PMS_SLOW_RISE_BIT]));
            fallSeen_reg <= slowFall || (fallSeen_reg &&
                !(regWrite && regAddr == `PMS_ADR_SLOW && regWdata[`PMS_SLOW_FALL_BIT]));
            if (regWrite && regAddr == `PMS_ADR_STATUS && regWdata[`PMS_STATUS_POR_BIT])
                porFlag_reg <= 1'b0;
        end
    end

    // rate period latched at cycle start
    // busy window also bounds result settling
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            timer_reg <= 32'h0;
            busy_reg  <= 32'h0;
            ssCnt_reg <= 32'h0;
            rate_reg  <= `PMS_MODE_1024;
        end else if (pdNow) begin
            timer_reg <= 32'h0;
            busy_reg  <= 32'h0;
            ssCnt_reg <= 32'h0;
            rate_reg  <= `PMS_MODE_1024;
        end else begin
            if (!periodic)
                timer_reg <= 32'h0;
            else if (startPer)
                timer_reg <= perSel - 32'h1;
            else if (timer_reg != 32'h0)
                timer_reg <= timer_reg - 32'h1;
            if (anySnap)
                busy_reg <= 32'(SNAP_CYC) - 32'h1;
            else if (busyWin)
                busy_reg <= busy_reg - 32'h1;
            if (shotTrig)
                ssCnt_reg <= 32'(SSDLY_CYC) - 32'h1;
            else if (ssCnt_reg != 32'h0)
                ssCnt_reg <= ssCnt_reg - 32'h1;
            if (startPer)
                rate_reg <= effMode;
            else if (ssDone)
                rate_reg <= mode;
        end
    end

    // results change only on samples, snapshots or power-down
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 4; i++) begin
                live_reg[i] <= '0;
                done_reg[i] <= '0;
                read_reg[i] <= '0;
                acc_reg[i]  <= 56'h0;
            end
            accCount_reg  <= 32'h0;
            readCount_reg <= 32'h0;
        end else if (pdNow) begin
            for (int i = 0; i < 4; i++) begin
                live_reg[i] <= '0;
                done_reg[i] <= '0;
                read_reg[i] <= '0;
                acc_reg[i]  <= 56'h0;
            end
            accCount_reg  <= 32'h0;
            readCount_reg <= 32'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (sampleIn && ch == 2'(i)) begin
                    live_reg[i] <= newRes;
                    acc_reg[i]  <= (clearAcc ? 56'h0 : acc_reg[i]) +
                                   {{26{prod[29]}}, prod[29:0]};
                end else if (clearAcc) begin
                    acc_reg[i] <= 56'h0;
                end
                if (cycleEnd)
                    done_reg[i] <= (ch == 2'(i)) ? newRes : live_reg[i];
                if (anySnap)
                    read_reg[i] <= done_reg[i];
            end
            if (anySnap)
                readCount_reg <= accCount_reg;
            accCount_reg <= (clearAcc ? 32'h0 : accCount_reg) + {31'h0, cycleEnd};
        end
    end

    wire [1:0]  rIdx    = regAddr[1:0];
    wire [7:0]  rBase   = {regAddr[7:2], 2'b00};
    wire [15:0] ctrlRd  = {4'h0, cfgPend_reg.chOff, 3'h0, cfgPend_reg.alertPin,
                           1'b0, cfgPend_reg.mode};
    wire [15:0] slowRd  = {9'h000, fallSeen_reg, riseSeen_reg, slowLvl, 1'b0,
                           slowCfg_reg[2:0]};
    wire [15:0] stateRd = {8'h00, rate_reg, busyWin, sleep_reg, state_reg};
    wire [15:0] rdMux   =
        (regAddr == `PMS_ADR_CTRL)    ? ctrlRd :
        (regAddr == `PMS_ADR_CNT_LO)  ? readCount_reg[15:0] :
        (regAddr == `PMS_ADR_CNT_HI)  ? readCount_reg[31:16] :
        (rBase == `PMS_ADR_BUS0)      ? read_reg[rIdx].bus :
        (rBase == `PMS_ADR_SENSE0)    ? read_reg[rIdx].sense :
        (rBase == `PMS_ADR_POWER0)    ? read_reg[rIdx].power[29:14] :
        (regAddr == `PMS_ADR_STATE)   ? stateRd :
        (regAddr == `PMS_ADR_STATUS)  ? {15'h0000, porFlag_reg} :
        (regAddr == `PMS_ADR_POLAR)   ? {8'h00, cfgPend_reg.busBip, cfgPend_reg.senseBip} :
        (regAddr == `PMS_ADR_HALF)    ? {8'h00, cfgPend_reg.busHalf, cfgPend_reg.senseHalf} :
        (regAddr == `PMS_ADR_SLOW)    ? slowRd : 16'h0000;
    // sleep depends on idle state, period timer, rate, slow pin level and alert use, channels and mode only
    wire sleepNext = idle && !startPer && (modeSleep || mode != `PMS_MODE_1024 ||
                     (slowLvl && pinIsIo) || (|cfgAct_reg.chOff));

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg   <= 16'h0000;
            nack_reg    <= 1'b0;
            conv_reg    <= 1'b0;
            sleep_reg   <= 1'b0;
            pd_reg      <= 1'b0;
            alarm_reg   <= 1'b0;
            alarmOe_reg <= 1'b0;
        end else begin
            rdata_reg   <= (regRead && !pdNow) ? rdMux : 16'h0000;
            nack_reg    <= wrCmd && busyWin;
            conv_reg    <= !pdNow && (startPer || ssDone);
            sleep_reg   <= !pdNow && sleepNext;
            pd_reg      <= pdNow;
            // alert use leaves mode table intact
            alarm_reg   <= !pdNow && cfgAct_reg.alertPin && alarmRequest;
            alarmOe_reg <= !pdNow && cfgAct_reg.alertPin;
        end
    end

    assign regRdata        = rdata_reg;
    assign cmdNack         = nack_reg;
    assign convStart       = conv_reg;
    assign cycleRate       = rate_reg;
    assign sleepActive     = sleep_reg;
    assign powerDownActive = pd_reg;
    assign firstAlarmOut   = alarm_reg;
    assign firstAlarmOe    = alarmOe_reg;
endmodule // pms_top
